/* artc_defs.vh */
// constants shared by the round-transform and carry-less multiply block
`ifndef ARTC_DEFS_VH
`define ARTC_DEFS_VH

// ---------------------------------------------------------------
// operation codes on opCode
// ---------------------------------------------------------------
`define ARTC_OP_WORD_SUB    3'h0
`define ARTC_OP_INV_MIX     3'h1
`define ARTC_OP_INV_ROW     3'h2
`define ARTC_OP_INV_SUB     3'h3
`define ARTC_OP_CLMUL       3'h4
`define ARTC_OP_FIELD_MUL   3'h5

// ---------------------------------------------------------------
// field arithmetic
// ---------------------------------------------------------------
`define ARTC_FIELD_POLY     8'h1b
`define ARTC_MIX_C0         8'h0e
`define ARTC_MIX_C1         8'h0b
`define ARTC_MIX_C2         8'h0d
`define ARTC_MIX_C3         8'h09

// ---------------------------------------------------------------
// identification word and reset values
// ---------------------------------------------------------------
`define ARTC_ID_CIPHER_BIT  25
`define ARTC_ID_CLMUL_BIT   1
`define ARTC_ID_ECX_RESET   32'h0200_0002
`define ARTC_RESULT_RESET   128'h0000_0000_0000_0000_0000_0000_0000_0000
`define ARTC_FLAG_RESET     1'h1

`endif

/* artc_sub_rom.v */
// forward and inverse byte substitution tables, sixteen registered lanes
`timescale 1ns/1ps
`include "artc_defs.vh"

module artc_sub_rom
(
  input  wire         sys_clk,
  input  wire         rst_n,
  input  wire         lookupInverse,
  input  wire [127:0] lookupIn,
  output reg  [127:0] lookupOut_q
);

  // ---------------------------------------------------------------
  // tables, entry 00 in the top byte, row-major by upper nibble
  // ---------------------------------------------------------------
  localparam [2047:0] FWD_TABLE = {
    128'h637c_777b_f26b_6fc5_3001_672b_fed7_ab76,
    128'hca82_c97d_fa59_47f0_add4_a2af_9ca4_72c0,
    128'hb7fd_9326_363f_f7cc_34a5_e5f1_71d8_3115,
    128'h04c7_23c3_1896_059a_0712_80e2_eb27_b275,
    128'h0983_2c1a_1b6e_5aa0_523b_d6b3_29e3_2f84,
    128'h53d1_00ed_20fc_b15b_6acb_be39_4a4c_58cf,
    128'hd0ef_aafb_434d_3385_45f9_027f_503c_9fa8,
    128'h51a3_408f_929d_38f5_bcb6_da21_10ff_f3d2,
    128'hcd0c_13ec_5f97_4417_c4a7_7e3d_645d_1973,
    128'h6081_4fdc_222a_9088_46ee_b814_de5e_0bdb,
    128'he032_3a0a_4906_245c_c2d3_ac62_9195_e479,
    128'he7c8_376d_8dd5_4ea9_6c56_f4ea_657a_ae08,
    128'hba78_252e_1ca6_b4c6_e8dd_741f_4bbd_8b8a,
    128'h703e_b566_4803_f60e_6135_57b9_86c1_1d9e,
    128'he1f8_9811_69d9_8e94_9b1e_87e9_ce55_28df,
    128'h8ca1_890d_bfe6_4268_4199_2d0f_b054_bb16};

  localparam [2047:0] INV_TABLE = {
    128'h5209_6ad5_3036_a538_bf40_a39e_81f3_d7fb,
    128'h7ce3_3982_9b2f_ff87_348e_4344_c4de_e9cb,
    128'h547b_9432_a6c2_233d_ee4c_950b_42fa_c34e,
    128'h082e_a166_28d9_24b2_765b_a249_6d8b_d125,
    128'h72f8_f664_8668_9816_d4a4_5ccc_5d65_b692,
    128'h6c70_4850_fded_b9da_5e15_4657_a78d_9d84,
    128'h90d8_ab00_8cbc_d30a_f7e4_5805_b8b3_4506,
    128'hd02c_1e8f_ca3f_0f02_c1af_bd03_0113_8a6b,
    128'h3a91_1141_4f67_dcea_97f2_cfce_f0b4_e673,
    128'h96ac_7422_e7ad_3585_e2f9_37e8_1c75_df6e,
    128'h47f1_1a71_1d29_c589_6fb7_620e_aa18_be1b,
    128'hfc56_3e4b_c6d2_7920_9adb_c0fe_78cd_5af4,
    128'h1fdd_a833_8807_c731_b112_1059_2780_ec5f,
    128'h6051_7fa9_19b5_4a0d_2de5_7a9f_93c9_9cef,
    128'ha0e0_3b4d_ae2a_f5b0_c8eb_bb3c_8353_9961,
    128'h172b_047e_ba77_d626_e169_1463_5521_0c7d};

  // one table read: upper nibble picks the row, lower the column
  function [7:0] pick;
    input       inv;
    input [7:0] idx;
    reg   [11:0] pos;
    begin
      pos  = 12'd2047 - {1'b0, idx, 3'b000};                 // R1
      pick = inv ? INV_TABLE[pos -: 8] : FWD_TABLE[pos -: 8]; // R2 R7
    end
  endfunction

  // every lane is looked up on its own and keeps its byte slot
  integer k;
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      lookupOut_q <= `ARTC_RESULT_RESET;
    else
    begin
      for (k = 0; k < 16; k = k + 1)
        lookupOut_q[8*k +: 8] <= pick(lookupInverse, lookupIn[8*k +: 8]); // R3 R8
    end
  end

endmodule // artc_sub_rom

/* artc_transform_unit.v */
// round transforms, field multiply and carry-less multiply with id flags
//
// Notes on behaviour
// (R1) lookups index a 16x16 table: upper nibble row, lower nibble column
// (R2) forward table holds the standard values, 00->63, 01->7c, ff->16
// (R3) word substitution maps each of four bytes in place through forward table
// (R4) inverse mix row 0 uses 0e,0b,0d,09 on rows 0..3, XOR combined
// (R5) rows 1..3 use that sequence rotated right per row; columns independent
// (R6) inverse row rotate keeps row 0, rotates rows 1..3 right by 1,2,3
// (R7) inverse table holds the standard values, 00->52, 01->09, ff->7d
// (R8) inverse substitution maps all sixteen bytes in place
// (R9) carry-less multiply: 64x64 to 128-bit product, XOR partials, no carries
// (R10) identification word bit 25 reads 1: cipher round functions present
// (R11) identification word bit 1 reads 1: carry-less multiply present
// (R12) software checks both flags before issuing operations here
// (R13) field multiply is carry-less byte product reduced modulo 11b
// (R14) matrix element row i column j is state byte 4j+i; column j is word j
// (R15) results are registered; reset clears result registers to zero
`timescale 1ns/1ps
`include "artc_defs.vh"

module artc_transform_unit
(
  input  wire         sys_clk,
  input  wire         rst_n,
  input  wire         opValid,
  input  wire [2:0]   opCode,
  input  wire [127:0] operandA,
  input  wire [127:0] operandB,
  output reg          resultValid_q,
  output reg  [127:0] result_q,
  output reg          illegalOp_q,
  output reg  [31:0]  identEcx_q,
  output reg          cipherRoundSupportFlag_q,
  output reg          carrylessSupportFlag_q
);

  // ---------------------------------------------------------------
  // arithmetic helpers
  // ---------------------------------------------------------------

  // byte product in the cipher field, shift-and-add with reduction
  function [7:0] fieldMultiply;
    input [7:0] a;
    input [7:0] b;
    reg   [7:0] acc;
    reg   [7:0] sh;
    integer     n;
    begin
      acc = 8'h00;
      sh  = a;
      for (n = 0; n < 8; n = n + 1)
      begin
        if (b[n])
          acc = acc ^ sh;
        sh = sh[7] ? ({sh[6:0], 1'b0} ^ `ARTC_FIELD_POLY) : {sh[6:0], 1'b0}; // R13
      end
      fieldMultiply = acc;
    end
  endfunction

  // state byte at matrix row i, column j
  function [7:0] stateByte;
    input [127:0] s;
    input [1:0]   i;
    input [1:0]   j;
    begin
      stateByte = s[{j, i, 3'b000} +: 8]; // R14
    end
  endfunction

  // one output byte of the inverse column mix; row selects the rotation
  function [7:0] mixByte;
    input [31:0] col;
    input [1:0]  row;
    reg   [31:0] coef;
    integer      r;
    begin
      coef = {`ARTC_MIX_C3, `ARTC_MIX_C2, `ARTC_MIX_C1, `ARTC_MIX_C0}; // R4
      // rotate the constant sequence right once per row
      for (r = 0; r < 3; r = r + 1)
        if (r < row)
          coef = {coef[23:0], coef[31:24]}; // R5
      mixByte = fieldMultiply(coef[7:0],   col[7:0])   ^
                fieldMultiply(coef[15:8],  col[15:8])  ^
                fieldMultiply(coef[23:16], col[23:16]) ^
                fieldMultiply(coef[31:24], col[31:24]); // R4
    end
  endfunction

  // whole-state inverse column mix, each column alone
  function [127:0] inverseColumnMix;
    input [127:0] s;
    integer       j;
    integer       i;
    begin
      inverseColumnMix = 128'h0;
      for (j = 0; j < 4; j = j + 1)
        for (i = 0; i < 4; i = i + 1)
          inverseColumnMix[32*j + 8*i +: 8] = mixByte(s[32*j +: 32], i[1:0]); // R5
    end
  endfunction

  // row i moves i places toward higher column: out(i,j) = in(i,j-i)
  function [127:0] inverseRowRotate;
    input [127:0] s;
    integer       j;
    integer       i;
    reg   [1:0]   src;
    begin
      inverseRowRotate = 128'h0;
      for (j = 0; j < 4; j = j + 1)
        for (i = 0; i < 4; i = i + 1)
        begin
          src = j[1:0] - i[1:0];                                           // R6
          inverseRowRotate[32*j + 8*i +: 8] = stateByte(s, i[1:0], src);  // R14
        end
    end
  endfunction

  // polynomial product over GF(2); one XOR-shift per operand bit
  function [127:0] carrylessMultiply;
    input [63:0] a;
    input [63:0] b;
    integer      n;
    begin
      carrylessMultiply = 128'h0;
      for (n = 0; n < 64; n = n + 1)
        if (b[n])
          carrylessMultiply = carrylessMultiply ^ ({64'h0, a} << n); // R9
    end
  endfunction

  // ---------------------------------------------------------------
  // substitution lanes
  // ---------------------------------------------------------------

  // table lookups sit in a registered memory, so every operation takes
  // the same two-edge path and no result can overtake another
  wire [127:0] subOut;
  wire         useInverse;

  assign useInverse = (opCode == `ARTC_OP_INV_SUB);

  artc_sub_rom subRom
  (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .lookupInverse(useInverse),
    .lookupIn     (operandA),
    .lookupOut_q  (subOut)
  );

  // ---------------------------------------------------------------
  // stage one: direct computation and bookkeeping
  // ---------------------------------------------------------------
  reg [127:0] compute_d;
  reg         legal_d;

  // result of the operations that need no table
  always @*
  begin
    compute_d = `ARTC_RESULT_RESET;
    legal_d   = 1'b1;
    case (opCode)
      `ARTC_OP_WORD_SUB  : compute_d = `ARTC_RESULT_RESET;
      `ARTC_OP_INV_SUB   : compute_d = `ARTC_RESULT_RESET;
      `ARTC_OP_INV_MIX   : compute_d = inverseColumnMix(operandA);
      `ARTC_OP_INV_ROW   : compute_d = inverseRowRotate(operandA);
      `ARTC_OP_CLMUL     : compute_d = carrylessMultiply(operandA[63:0], operandB[63:0]);
      `ARTC_OP_FIELD_MUL : compute_d = {120'h0, fieldMultiply(operandA[7:0], operandB[7:0])};
      default            : legal_d = 1'b0;
    endcase
  end

  reg         stageValid_q;
  reg [2:0]   stageOp_q;
  reg         stageLegal_q;
  reg [127:0] stageCompute_q;

  // capture the request alongside the table lookup
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stageValid_q   <= 1'b0;
      stageOp_q      <= `ARTC_OP_WORD_SUB;
      stageLegal_q   <= 1'b0;
      stageCompute_q <= `ARTC_RESULT_RESET;
    end
    else
    begin
      stageValid_q   <= opValid;
      stageOp_q      <= opCode;
      stageLegal_q   <= legal_d;
      stageCompute_q <= compute_d;
    end
  end

  // ---------------------------------------------------------------
  // stage two: select and present
  // ---------------------------------------------------------------
  reg [127:0] result_d;

  // word substitution exposes only the low word; upper bits read zero
  always @*
  begin
    case (stageOp_q)
      `ARTC_OP_WORD_SUB : result_d = {96'h0, subOut[31:0]}; // R3
      `ARTC_OP_INV_SUB  : result_d = subOut;                // R8
      default           : result_d = stageCompute_q;
    endcase
  end

  // result holds until the next accepted request replaces it
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resultValid_q <= 1'b0;                   // R15
      result_q      <= `ARTC_RESULT_RESET;     // R15
      illegalOp_q   <= 1'b0;
    end
    else
    begin
      resultValid_q <= stageValid_q;
      illegalOp_q   <= stageValid_q & ~stageLegal_q;
      if (stageValid_q)
        result_q <= stageLegal_q ? result_d : `ARTC_RESULT_RESET; // R15
    end
  end

  // ---------------------------------------------------------------
  // identification flags
  // ---------------------------------------------------------------

  // both features are built in, so the flags are constant from reset on;
  // software is expected to read them before issuing anything (R12)
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      identEcx_q               <= `ARTC_ID_ECX_RESET;
      cipherRoundSupportFlag_q <= `ARTC_FLAG_RESET;
      carrylessSupportFlag_q   <= `ARTC_FLAG_RESET;
    end
    else
    begin
      identEcx_q               <= `ARTC_ID_ECX_RESET;
      cipherRoundSupportFlag_q <= identEcx_q[`ARTC_ID_CIPHER_BIT]; // R10
      carrylessSupportFlag_q   <= identEcx_q[`ARTC_ID_CLMUL_BIT];  // R11
    end
  end

endmodule // artc_transform_unit

/* artc_monitor.sv */
// checker bound to the transform unit ports
`timescale 1ns/1ps
`include "artc_defs.vh"
module artc_monitor
(
  input wire         sys_clk,
  input wire         rst_n,
  input wire         opValid,
  input wire [2:0]   opCode,
  input wire [127:0] operandA,
  input wire [127:0] operandB,
  input wire         resultValid_q,
  input wire [127:0] result_q,
  input wire         illegalOp_q,
  input wire [31:0]  identEcx_q,
  input wire         cipherRoundSupportFlag_q,
  input wire         carrylessSupportFlag_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // answers come two edges after the request, never unasked
  a_answer_lat: assert property (opValid |-> ##2 resultValid_q)
    else $error("answer missing two cycles after request");
  a_no_spurious: assert property (resultValid_q |-> $past(opValid, 2))
    else $error("answer without request");
  a_result_hold: assert property (!resultValid_q |-> $stable(result_q))
    else $error("result changed without answer");
  a_illegal_zero: assert property (illegalOp_q |-> resultValid_q && result_q == 128'h0)
    else $error("illegal op gave data");
  a_word_upper: assert property (resultValid_q && $past(opCode, 2) == `ARTC_OP_WORD_SUB
    |-> result_q[127:32] == 96'h0)
    else $error("word result has upper bits");
  a_clmul_top: assert property (resultValid_q && $past(opCode, 2) == `ARTC_OP_CLMUL
    |-> !result_q[127])
    else $error("product wider than 127 bits");
  a_row0_keep: assert property (resultValid_q && $past(opCode, 2) == `ARTC_OP_INV_ROW
    |-> result_q[7:0] == $past(operandA[7:0], 2)
    && result_q[103:96] == $past(operandA[103:96], 2))
    else $error("row zero moved");
  a_fmul_unit: assert property (resultValid_q && $past(opCode, 2) == `ARTC_OP_FIELD_MUL
    && $past(operandA[7:0], 2) == 8'h01 |-> result_q == {120'h0, $past(operandB[7:0], 2)})
    else $error("multiply by one changed byte");
  a_ident_const: assert property (identEcx_q == `ARTC_ID_ECX_RESET)
    else $error("identification word wrong");
  a_flags_set: assert property (cipherRoundSupportFlag_q && carrylessSupportFlag_q)
    else $error("support flag low");
endmodule // artc_monitor

bind artc_transform_unit artc_monitor i_mon
(
  .sys_clk(sys_clk), .rst_n(rst_n), .opValid(opValid), .opCode(opCode),
  .operandA(operandA), .operandB(operandB), .resultValid_q(resultValid_q),
  .result_q(result_q), .illegalOp_q(illegalOp_q), .identEcx_q(identEcx_q),
  .cipherRoundSupportFlag_q(cipherRoundSupportFlag_q),
  .carrylessSupportFlag_q(carrylessSupportFlag_q)
);

/* artc_pipe_model.sv */
// execution pipeline model that issues requests at the falling edge
`timescale 1ns/1ps
module artc_pipe_model
(
  input  wire         sys_clk,
  input  wire         cipherOk,
  input  wire         clmulOk,
  output reg          opValid,
  output reg  [2:0]   opCode,
  output reg  [127:0] operandA,
  output reg  [127:0] operandB
);
  integer n;
  initial
  begin
    opValid = 1'b0;
    opCode = 3'h0;
    operandA = 128'h0;
    operandB = 128'h0;
  end
  // back-to-back calls keep the strobe high; flags gate issue
  task issue(input [2:0] c, input [127:0] a, input [127:0] b);
    begin
      n = 0;
      while ((cipherOk & clmulOk) !== 1'b1 && n < 16)
      begin
        @(negedge sys_clk);
        n = n + 1;
      end
      @(negedge sys_clk);
      // no request goes out unless both support flags were confirmed
      opValid = ((cipherOk & clmulOk) === 1'b1);
      opCode = c;
      operandA = a;
      operandB = b;
    end
  endtask
  // idle operands flip so stale data cannot pass for held data
  task idle;
    begin
      @(negedge sys_clk);
      opValid = 1'b0;
      operandA = ~operandA;
      operandB = ~operandB;
    end
  endtask
endmodule // artc_pipe_model

/* artc_transform_unit_bench.sv */
// self-checking bench for the transform unit
`timescale 1ns/1ps
module artc_transform_unit_bench;
  typedef struct packed {logic [2:0] op; logic [127:0] a, b; logic [128:0] e;} artc_row_t;
  logic         sys_clk = 1'b0, rst_n, opValid, resultValid_q, illegalOp_q, cFlag, mFlag;
  logic [2:0]   opCode;
  logic [127:0] operandA, operandB, result_q, a;
  logic [31:0]  identEcx_q;
  logic [128:0] expQ[$], e;
  logic [7:0]   sb[256], ib[256], mc[4], v;
  artc_row_t    rows[9];
  integer       fails = 0, checked = 0, x, y, k;
  always #12.5 sys_clk = ~sys_clk;
  artc_pipe_model i_pipe (.sys_clk(sys_clk), .cipherOk(cFlag), .clmulOk(mFlag),
    .opValid(opValid), .opCode(opCode), .operandA(operandA), .operandB(operandB));
  artc_transform_unit i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .opValid(opValid),
    .opCode(opCode), .operandA(operandA), .operandB(operandB), .resultValid_q(resultValid_q),
    .result_q(result_q), .illegalOp_q(illegalOp_q), .identEcx_q(identEcx_q),
    .cipherRoundSupportFlag_q(cFlag), .carrylessSupportFlag_q(mFlag));
  task cmp(input [128:0] got, input [128:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  function [7:0] gm(input [7:0] p, input [7:0] q);
    integer i;
    begin
      gm = 8'h00;
      for (i = 0; i < 8; i = i + 1)
      begin
        if (q[i]) gm = gm ^ p;
        p = {p[6:0], 1'b0} ^ (p[7] ? 8'h1b : 8'h00);
      end
    end
  endfunction
  // reference result with the illegal flag on top
  function [128:0] ex(input [2:0] op, input [127:0] s, input [127:0] t);
    integer i, j, m;
    reg [127:0] r;
    begin
      r = 128'h0;
      for (j = 0; j < 4; j = j + 1)
        for (i = 0; i < 4; i = i + 1)
          case (op)
            3'h0: if (j == 0) r[8*i +: 8] = sb[s[8*i +: 8]];
            3'h1: for (m = 0; m < 4; m = m + 1)
              r[32*j+8*i +: 8] = r[32*j+8*i +: 8] ^ gm(mc[(m-i)&3], s[32*j+8*m +: 8]);
            3'h2: r[32*j+8*i +: 8] = s[32*((j-i)&3)+8*i +: 8];
            3'h3: r[32*j+8*i +: 8] = ib[s[32*j+8*i +: 8]];
            default: ;
          endcase
      if (op == 3'h4) for (m = 0; m < 64; m = m + 1) if (t[m]) r = r ^ ({64'h0, s[63:0]} << m);
      if (op == 3'h5) r[7:0] = gm(s[7:0], t[7:0]);
      ex = {op > 3'h5, r};
    end
  endfunction
  // answers checked in request order at the settled falling edge
  always @(negedge sys_clk)
    if (resultValid_q !== 1'b0)
    begin
      e = (expQ.size() == 0) ? {129{1'b1}} : expQ.pop_front();
      cmp({illegalOp_q, result_q}, e);
    end
  initial
  begin
    #(25 * 3000);
    fails = fails + 1;
    conclude;
  end
  initial
  begin
    rst_n = 1'b0;
    mc = '{8'h0e, 8'h0b, 8'h0d, 8'h09};
    for (x = 0; x < 256; x = x + 1)
    begin
      v = 8'h00;
      for (y = 1; y < 256; y = y + 1) if (gm(x, y) == 8'h01) v = y;
      v = v ^ {v[6:0], v[7]} ^ {v[5:0], v[7:6]} ^ {v[4:0], v[7:5]} ^ {v[3:0], v[7:4]} ^ 8'h63;
      sb[x] = v;
      ib[v] = x;
    end
    rows[0] = '{3'h0, 128'h00ff_0100, 128'h0, 129'h6316_7c63};
    rows[1] = '{3'h3, 128'h00ff_0100, 128'h0, 129'h5252_5252_5252_5252_5252_5252_527d_0952};
    rows[2] = '{3'h5, 128'h57, 128'h83, 129'hc1};
    rows[3] = '{3'h5, 128'h01, 128'hc3, 129'hc3};
    rows[4] = '{3'h4, 128'h3, 128'h3, 129'h5};
    rows[5] = '{3'h1, 128'hbca1_4d8e, 128'h0, 129'h4553_13db};
    rows[6] = '{3'h2, 128'h0f0e_0d0c_0b0a_0908_0706_0504_0302_0100, 128'h0,
                129'h0306_090c_0f02_0508_0b0e_0104_070a_0d00};
    rows[7] = '{3'h6, 128'h1, 128'h1, {1'b1, 128'h0}};
    rows[8] = '{3'h4, 128'h8000_0000_0000_0000, 128'h8000_0000_0000_0000, 129'h1 << 126};
    repeat (8) @(negedge sys_clk);
    cmp({resultValid_q | illegalOp_q, result_q}, 129'h0);
    cmp({95'h0, identEcx_q, cFlag, mFlag}, {95'h0, 32'h0200_0002, 2'b11});
    rst_n = 1'b1;
    // every opcode back to back, all 256 table entries swept
    for (k = 0; k < 512; k = k + 1)
    begin
      for (x = 0; x < 16; x = x + 1) a[8*x +: 8] = 4 * (k / 8) + x;
      expQ.push_back(ex(k % 8, a, {a[63:0], a[127:64]} ^ {16{8'h5a}}));
      i_pipe.issue(k % 8, a, {a[63:0], a[127:64]} ^ {16{8'h5a}});
    end
    for (k = 0; k < 9; k = k + 1)
    begin
      expQ.push_back(rows[k].e);
      i_pipe.issue(rows[k].op, rows[k].a, rows[k].b);
    end
    i_pipe.idle;
    repeat (6) @(negedge sys_clk);
    cmp({expQ.size() != 0, result_q}, 129'h1 << 126);
    // reset lands while a request is in flight
    i_pipe.issue(3'h5, 128'h57, 128'h83);
    i_pipe.idle;
    rst_n = 1'b0;
    @(negedge sys_clk);
    cmp({resultValid_q | illegalOp_q, result_q}, 129'h0);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    cmp({95'h0, identEcx_q, cFlag, mFlag}, {95'h0, 32'h0200_0002, 2'b11});
    conclude;
  end
endmodule // artc_transform_unit_bench
